// >>> crap_chan_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Remote channel-end: sends requests, gathers replies
module crap_chan_model (
    input wire mclk,
    input wire reset,
    output logic rx_valid,
    output logic rx_ctrl,
    output logic [7:0] rx_data,
    input wire rx_ready,
    input wire tx_valid,
    input wire tx_ctrl,
    input wire [7:0] tx_data,
    output logic tx_ready
);
    logic [8:0] got[$];
    logic hung = 1'b0;
    // Channel-end destination of this bank; routing lies outside the block
    localparam logic [15:0] CRAP_TILE_ID = 16'h0001; // Arbitrary tile id
    wire [31:0] dest = {CRAP_TILE_ID, 16'hC20C};
    initial begin
        rx_valid = 1'b0;
        rx_ctrl = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    // Takes reply bytes, stalling now and then
    always @(posedge mclk) begin
        if (tx_valid && tx_ready)
            got.push_back({tx_ctrl, tx_data});
        tx_ready <= !reset && ($urandom % 3 != 0);
    end
    // One byte, held until the interpreter takes it
    task put(input logic c, input logic [7:0] b);
        int n;
        n = 0;
        rx_valid <= 1'b1;
        rx_ctrl <= c;
        rx_data <= b;
        do @(negedge mclk); while (!rx_ready && n++ < 300);
        if (!rx_ready) hung = 1'b1;
        @(posedge mclk);
    endtask
    // Message with an unknown lead token, to be drained silently
    task stray(input logic [7:0] t);
        put(1'b1, t);
        put(1'b0, t);
        put(1'b1, 8'h01);
        rx_valid <= 1'b0;
        rx_ctrl <= 1'b0;
        rx_data <= ~rx_data;
    endtask
    // Whole request, fields most significant byte first
    task send(input logic wr, input logic [23:0] a, input logic [15:0] r,
              input logic [31:0] d);
        put(1'b1, wr ? 8'hC0 : 8'hC1);
        for (int i = 2; i >= 0; i--) put(1'b0, a[i*8 +: 8]);
        for (int i = 1; i >= 0; i--) put(1'b0, r[i*8 +: 8]);
        if (wr) for (int i = 3; i >= 0; i--) put(1'b0, d[i*8 +: 8]);
        put(1'b1, 8'h01);
        rx_valid <= 1'b0;
        rx_ctrl <= 1'b0;
        rx_data <= ~rx_data; // Released line shows no stale byte
    endtask
endmodule // crap_chan_model
`default_nettype wire

// >>> crap_interp.v
`timescale 1ns/1ps
`default_nettype none
`include "crap_regs.vh"

// Functional notes
// (R1) Each request carries a 24-bit reply address of node and channel.
// (R2) A write whose reply address ends in 0xFF is done with no reply.
// (R3) Multi-byte fields travel most significant byte first both ways.
// (R4) Status resource identifier is register number shifted 8 OR 0x0B.
// (R5) Status registers move one word per access by local instructions.
// (R6) Requesters aim at the tile id with this bank's fixed low code.
// (R7) A write is token 192, address, register, data, token 1.
// (R8) Write reply is token 3 then 1 on success, 4 then 1 on failure.
// (R9) A read is token 193, address, register, token 1.
// (R10) Read reply is 3, data, 1 on success, or 4 then 1 on failure.
// (R11) Write success is sent only after the register holds new data.
module crap_interp (
    input wire mclk,
    input wire reset,
    input wire rx_valid,
    input wire rx_ctrl,
    input wire [7:0] rx_data,
    output reg rx_ready,
    output reg tx_valid,
    output reg tx_ctrl,
    output reg [7:0] tx_data,
    input wire tx_ready,
    output reg [23:0] reply_addr,
    input wire ps_req,
    input wire ps_write,
    input wire [15:0] ps_num,
    input wire [31:0] ps_wdata,
    output reg [31:0] ps_rdata,
    output reg [31:0] ps_resid,
    output reg ps_done
);
    // ========================================================
    // States
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_ADDR = 8'h02;
    localparam [7:0] S_REG = 8'h04;
    localparam [7:0] S_DATA = 8'h08;
    localparam [7:0] S_END = 8'h10;
    localparam [7:0] S_EXEC = 8'h20;
    localparam [7:0] S_REPLY = 8'h40;
    localparam [7:0] S_DRAIN = 8'h80;

    reg [7:0] state_reg;
    reg [2:0] cnt_reg;
    reg is_write_reg;
    reg ok_reg;
    reg [15:0] regnum_reg;
    reg [31:0] data_reg;
    reg [2:0] rcnt_reg;
    reg [31:0] bank [0:`CRAP_NUM_REGS-1];
    wire [31:0] resid;
    integer i;

    // In range when the upper register bits are zero
    function reg_hit;
        input [15:0] n;
        begin
            reg_hit = (n[15:`CRAP_REG_IDX_BITS] == 12'h000);
        end
    endfunction

    // Byte for reply sequence position
    function [8:0] reply_byte;
        input ok;
        input wr;
        input [2:0] pos;
        input [31:0] d;
        begin
            if (!ok) begin
                reply_byte = (pos == 3'h0) ? {1'b1, `CRAP_TOK_NACK}
                    : {1'b1, `CRAP_TOK_END}; // (R8) (R10)
            end else if (pos == 3'h0) begin
                reply_byte = {1'b1, `CRAP_TOK_ACK};
            end else if (wr || pos == 3'h5) begin
                reply_byte = {1'b1, `CRAP_TOK_END};
            end else begin
                reply_byte = {1'b0, d[8'h27 - {pos, 3'h0} -: 8]}; // (R3)
            end
        end
    endfunction

    function [2:0] reply_last;
        input ok;
        input wr;
        begin
            reply_last = (!ok || wr) ? 3'h1 : 3'h5;
        end
    endfunction

    crap_ps_map u_map (
        .ps_regnum(ps_num),
        .ps_resid(resid)
    );

    wire rx_take = rx_valid && rx_ready;
    wire [8:0] rb = reply_byte(ok_reg, is_write_reg, rcnt_reg, data_reg);
    // Bank index from the low register number bits
    wire [`CRAP_REG_IDX_BITS-1:0] reg_idx = regnum_reg[`CRAP_REG_IDX_BITS-1:0];

    // ========================================================
    // Request parse and reply engine
    always @(posedge mclk) begin
        if (reset) begin
            state_reg <= S_IDLE;
            cnt_reg <= 3'h0;
            rcnt_reg <= 3'h0;
            is_write_reg <= 1'b0;
            ok_reg <= 1'b0;
            regnum_reg <= 16'h0000;
            data_reg <= `CRAP_REG_RESET;
            reply_addr <= 24'h000000;
            rx_ready <= 1'b0;
            tx_valid <= 1'b0;
            tx_ctrl <= 1'b0;
            tx_data <= 8'h00;
            for (i = 0; i < `CRAP_NUM_REGS; i = i + 1) begin
                bank[i] <= `CRAP_REG_RESET;
            end
        end else begin
            rx_ready <= (state_reg != S_EXEC) && (state_reg != S_REPLY);
            case (state_reg)
                S_IDLE: begin
                    if (rx_take && rx_ctrl) begin
                        cnt_reg <= 3'h0;
                        ok_reg <= 1'b1;
                        if (rx_data == `CRAP_TOK_WRITE) begin // (R7)
                            is_write_reg <= 1'b1;
                            state_reg <= S_ADDR;
                        end else if (rx_data == `CRAP_TOK_READ) begin // (R9)
                            is_write_reg <= 1'b0;
                            state_reg <= S_ADDR;
                        end else if (rx_data != `CRAP_TOK_END) begin
                            state_reg <= S_DRAIN;
                        end
                    end
                end
                S_ADDR: begin
                    if (rx_take) begin
                        // Reply address, top byte first
                        reply_addr <= {reply_addr[15:0], rx_data}; // (R1) (R3)
                        if (rx_ctrl) begin
                            ok_reg <= 1'b0;
                        end
                        cnt_reg <= cnt_reg + 3'h1;
                        if (cnt_reg == `CRAP_ADDR_BYTES - 3'h1) begin
                            cnt_reg <= 3'h0;
                            state_reg <= S_REG;
                        end
                    end
                end
                S_REG: begin
                    if (rx_take) begin
                        regnum_reg <= {regnum_reg[7:0], rx_data}; // (R3)
                        if (rx_ctrl) begin
                            ok_reg <= 1'b0;
                        end
                        cnt_reg <= cnt_reg + 3'h1;
                        if (cnt_reg == `CRAP_REG_BYTES - 3'h1) begin
                            cnt_reg <= 3'h0;
                            state_reg <= is_write_reg ? S_DATA : S_END;
                        end
                    end
                end
                S_DATA: begin
                    if (rx_take) begin
                        data_reg <= {data_reg[23:0], rx_data}; // (R3)
                        if (rx_ctrl) begin
                            ok_reg <= 1'b0;
                        end
                        cnt_reg <= cnt_reg + 3'h1;
                        if (cnt_reg == `CRAP_DATA_BYTES - 3'h1) begin
                            state_reg <= S_END;
                        end
                    end
                end
                S_END: begin
                    if (rx_take) begin
                        // Close the request port before the execute cycle
                        rx_ready <= 1'b0;
                        if (!(rx_ctrl && rx_data == `CRAP_TOK_END)) begin
                            ok_reg <= 1'b0;
                        end
                        if (!reg_hit(regnum_reg)) begin
                            ok_reg <= 1'b0;
                        end
                        state_reg <= (rx_ctrl && rx_data == `CRAP_TOK_END)
                            ? S_EXEC : S_DRAIN;
                    end
                end
                S_EXEC: begin
                    // Register updated before the reply is started
                    if (ok_reg && is_write_reg) begin
                        bank[reg_idx] <= data_reg; // (R11)
                    end else if (ok_reg) begin
                        data_reg <= bank[reg_idx];
                    end
                    rcnt_reg <= 3'h0;
                    if (is_write_reg
                        && reply_addr[7:0] == `CRAP_NOREPLY_LOW) begin
                        state_reg <= S_IDLE; // (R2)
                    end else begin
                        state_reg <= S_REPLY;
                    end
                end
                S_REPLY: begin
                    // Emit one reply item per accepted handshake
                    if (!tx_valid || tx_ready) begin
                        if (tx_valid
                            && rcnt_reg == reply_last(ok_reg, is_write_reg)
                            + 3'h1) begin
                            tx_valid <= 1'b0;
                            state_reg <= S_IDLE;
                        end else begin
                            tx_valid <= 1'b1;
                            tx_ctrl <= rb[8]; // (R8) (R10)
                            tx_data <= rb[7:0];
                            rcnt_reg <= rcnt_reg + 3'h1;
                        end
                    end
                end
                S_DRAIN: begin
                    // Discard a malformed message up to its terminator
                    if (rx_take && rx_ctrl && rx_data == `CRAP_TOK_END) begin
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // Local status register access, one word per request
    always @(posedge mclk) begin
        if (reset) begin
            ps_rdata <= 32'h00000000;
            ps_resid <= 32'h00000000;
            ps_done <= 1'b0;
        end else begin
            ps_done <= ps_req; // (R5)
            if (ps_req) begin
                ps_resid <= resid; // (R4)
                ps_rdata <= ps_write ? ps_wdata : 32'h00000000;
            end
        end
    end
endmodule // crap_interp
`default_nettype wire

// >>> crap_interp_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the interpreter
module crap_interp_tb;
    typedef logic [8:0] crap_q_t[$];
    logic mclk = 1'b0, reset = 1'b1, ps_req = 1'b0, ps_write = 1'b0;
    logic [15:0] ps_num = 16'h0000;
    logic [31:0] ps_wdata = 32'h00000000, bank[16];
    wire rx_valid, rx_ctrl, rx_ready, tx_valid, tx_ctrl, tx_ready, ps_done;
    wire [7:0] rx_data, tx_data;
    wire [23:0] reply_addr;
    wire [31:0] ps_rdata, ps_resid;
    int fails = 0, check_count = 0;
    crap_q_t none;
    always #5 mclk = ~mclk;
    crap_interp dut_u (.mclk(mclk), .reset(reset), .rx_valid(rx_valid),
        .rx_ctrl(rx_ctrl), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_ctrl(tx_ctrl), .tx_data(tx_data),
        .tx_ready(tx_ready), .reply_addr(reply_addr), .ps_req(ps_req),
        .ps_write(ps_write), .ps_num(ps_num), .ps_wdata(ps_wdata),
        .ps_rdata(ps_rdata), .ps_resid(ps_resid), .ps_done(ps_done));
    crap_chan_model model_u (.mclk(mclk), .reset(reset), .rx_valid(rx_valid),
        .rx_ctrl(rx_ctrl), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_ctrl(tx_ctrl), .tx_data(tx_data),
        .tx_ready(tx_ready));
    task check(input logic [31:0] seen, input logic [31:0] exp, string what);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task conclude;
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Expected reply: token, data on a good read, end token
    function automatic crap_q_t reply(logic ok, logic rd, logic [31:0] d);
        reply = {ok ? 9'h103 : 9'h104};
        if (ok && rd)
            for (int i = 3; i >= 0; i--)
                reply.push_back({1'b0, d[i*8 +: 8]});
        reply.push_back(9'h101);
    endfunction
    // Waits for the reply, then compares it byte by byte
    task want(crap_q_t e);
        int n;
        n = 0;
        check(model_u.hung, 1'b0, "request accepted");
        while (model_u.got.size() < e.size() && n++ < 300) @(posedge mclk);
        if (n > 300) begin
            fails++;
            conclude;
        end
        repeat (8) @(posedge mclk);
        check(model_u.got.size(), e.size(), "reply length");
        foreach (e[i]) check(model_u.got[i], e[i], "reply byte");
        model_u.got.delete();
    endtask
    initial begin
        logic [23:0] a;
        logic [15:0] r;
        logic [31:0] d;
        logic wr, ok;
        void'($urandom(32'h2ECF));
        foreach (bank[i]) bank[i] = 32'h00000000;
        repeat (4) @(posedge mclk);
        check({rx_ready, tx_valid, ps_done}, 0, "reset outputs");
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        // Unknown lead token is drained without a reply
        model_u.stray(8'h05);
        want(none);
        // Random requests with bad numbers and silent writes among them
        for (int k = 0; k < 60; k++) begin
            wr = 1'($urandom % 2);
            r = (k % 5 == 0) ? 16'hFF00 | 16'(k) : 16'($urandom % 18);
            a = 24'($urandom);
            if (k % 4 == 1) a[7:0] = 8'hFF;
            d = $urandom;
            ok = r < 16;
            if (wr && ok) bank[r[3:0]] = d;
            model_u.send(wr, a, r, d);
            check(reply_addr, a, "reply address");
            if (wr && a[7:0] == 8'hFF) want(none);
            else want(reply(ok, !wr, bank[r[3:0]]));
            if (wr && ok) begin
                model_u.send(1'b0, a, r, 32'h00000000);
                want(reply(1'b1, 1'b1, d));
            end
        end
        // Status accesses, one idle cycle apart, extreme number first
        for (int k = 0; k < 20; k++) begin
            ps_num <= (k == 0) ? 16'hFFFF : 16'($urandom);
            ps_wdata <= $urandom;
            ps_write <= k[0];
            ps_req <= 1'b1;
            @(posedge mclk);
            ps_req <= 1'b0;
            @(negedge mclk);
            check(ps_resid, {8'h00, ps_num, 8'h0B}, "status id");
            check(ps_done, 1, "status done");
            check(ps_rdata, ps_write ? ps_wdata : 0, "status data");
            @(posedge mclk);
        end
        conclude;
    end
endmodule // crap_interp_tb
`default_nettype wire

// >>> crap_props.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Protocol checker on the interpreter ports
module crap_props (
    input wire mclk,
    input wire reset,
    input wire rx_valid,
    input wire rx_ctrl,
    input wire [7:0] rx_data,
    input wire rx_ready,
    input wire tx_valid,
    input wire tx_ctrl,
    input wire [7:0] tx_data,
    input wire tx_ready,
    input wire [23:0] reply_addr,
    input wire ps_req,
    input wire [15:0] ps_num,
    input wire [31:0] ps_resid,
    input wire ps_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire term = rx_valid && rx_ready && rx_ctrl && rx_data == 8'h01;
    wire lead = rx_valid && rx_ready && rx_ctrl && rx_data[7:1] == 7'h60;
    wire quiet;
    wire done;
    reg wr_reg;
    reg busy_reg;
    // Tracks a read or write message from its lead token to its end
    always @(posedge mclk) begin
        if (reset) begin
            wr_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else if (term) begin
            busy_reg <= 1'b0;
        end else if (lead && !busy_reg) begin
            wr_reg <= !rx_data[0];
            busy_reg <= 1'b1;
        end
    end
    assign quiet = wr_reg && reply_addr[7:0] == 8'hFF;
    // End of a read or write, not of a message with another lead token
    assign done = term && busy_reg;
    AST_NO_REPLY: assert property (done && quiet |=> !tx_valid [*8])
        else $error("reply sent for a silent write");
    AST_REPLY_TIME: assert property (done && !quiet |=>
        !tx_valid [*2] ##1
        (tx_valid && tx_ctrl && (tx_data == 8'h03 || tx_data == 8'h04)))
        else $error("reply token late or wrong");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable({tx_ctrl, tx_data}))
        else $error("reply byte changed before taken");
    AST_RX_BLOCK: assert property (tx_valid |-> !rx_ready)
        else $error("request taken during reply");
    AST_NACK_END: assert property (tx_valid && tx_ready && tx_ctrl &&
        tx_data == 8'h04 |-> ##[1:3] (tx_valid && tx_ctrl && tx_data == 8'h01))
        else $error("failure token not closed");
    AST_PS_ID: assert property (ps_req |=>
        ps_resid == {8'h00, $past(ps_num), 8'h0B})
        else $error("status resource id wrong");
    AST_PS_DONE: assert property (ps_req |=> ps_done)
        else $error("status access not done");
    AST_PS_SRC: assert property (ps_done |-> $past(ps_req))
        else $error("status done without request");
    COV_ACK: cover property (tx_valid && tx_ready && tx_ctrl &&
        tx_data == 8'h03);
    COV_NACK: cover property (tx_valid && tx_ready && tx_ctrl &&
        tx_data == 8'h04);
    COV_QUIET: cover property (done && quiet);
endmodule // crap_props
bind crap_interp crap_props props_u (.mclk(mclk), .reset(reset),
    .rx_valid(rx_valid), .rx_ctrl(rx_ctrl), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ctrl(tx_ctrl),
    .tx_data(tx_data), .tx_ready(tx_ready), .reply_addr(reply_addr),
    .ps_req(ps_req), .ps_num(ps_num), .ps_resid(ps_resid), .ps_done(ps_done));
`default_nettype wire

// >>> crap_ps_map.v
`timescale 1ns/1ps
`default_nettype none
`include "crap_regs.vh"

// ============================================================
// Status register number to resource identifier
module crap_ps_map (
    input wire [15:0] ps_regnum,
    output wire [31:0] ps_resid
);
    // Shift number up one byte and tag with the status type
    assign ps_resid = ({16'h0000, ps_regnum} << `CRAP_PS_SHIFT)
        | `CRAP_PS_TYPE; // (R4)
endmodule // crap_ps_map
`default_nettype wire

// >>> crap_regs.vh
`ifndef CRAP_REGS_VH
`define CRAP_REGS_VH

// ============================================================
// Control tokens
`define CRAP_TOK_WRITE 8'hC0
`define CRAP_TOK_READ 8'hC1
`define CRAP_TOK_END 8'h01
`define CRAP_TOK_ACK 8'h03
`define CRAP_TOK_NACK 8'h04

// ============================================================
// Field widths in bytes
`define CRAP_ADDR_BYTES 3'h3
`define CRAP_REG_BYTES 3'h2
`define CRAP_DATA_BYTES 3'h4

// ============================================================
// Reply suppression and status resource identifier
`define CRAP_NOREPLY_LOW 8'hFF
`define CRAP_PS_SHIFT 8
`define CRAP_PS_TYPE 32'h0000000B

// ============================================================
// Register bank size and reset value
`define CRAP_NUM_REGS 16
`define CRAP_REG_IDX_BITS 4
`define CRAP_REG_RESET 32'h00000000

`endif
